/* hdl/hcb_consts.svh */
`ifndef HCB_CONSTS_SVH
`define HCB_CONSTS_SVH
`define HCB_SFR_ADDR_SEL      8'h93
`define HCB_SFR_DATA_PORT     8'h94
`define HCB_CFG_BYTE_ZERO     7'h7f
`define HCB_CFG_BYTE_ONE      7'h7e
`define HCB_ADDR_RESET        8'h00
`define HCB_ERASED_BYTE       8'hff
`define HCB_B0_SECURITY       7
`define HCB_B0_PROG_LOCK      6
`define HCB_B0_RESET_LOCK     5
`define HCB_B0_BOOT_ROM       4
`define HCB_B0_WDOG_RESET     3
`define HCB_B0_DFLASH_HI      2
`define HCB_B0_DFLASH_LO      0
`define HCB_B1_DBO_HI         7
`define HCB_B1_DBO_LO         6
`define HCB_B1_ABO_HI         5
`define HCB_B1_ABO_LO         4
`define HCB_B1_ABO_DIS        3
`define HCB_B1_DBO_DIS        2
`define HCB_B1_P0_GPIO        1
`define HCB_B1_P23_GPIO       0
`endif

/* hdl/hcb_pkg.sv */
package hcb_pkg;
   typedef logic [7:0] hcb_byte_t;
   typedef logic [6:0] hcb_config_address_select_t;
   typedef enum logic [1:0] {HCB_BO_4V5, HCB_BO_4V2, HCB_BO_2V7, HCB_BO_2V5} hcb_bo_level_e;
   typedef enum logic [2:0] {HCB_DF_RSVD, HCB_DF_32K, HCB_DF_16K, HCB_DF_8K,
                             HCB_DF_4K, HCB_DF_2K, HCB_DF_1K, HCB_DF_NONE} hcb_dflash_e;
endpackage

/* hdl/hcb_mem_if.sv */
`timescale 1ns/1ps
interface hcb_mem_if;
   logic       we;
   logic [6:0] waddr;
   logic [7:0] wdata;
   logic [6:0] raddr;
   logic [7:0] rdata;
   logic       erase;
   modport ctrl (output we, output waddr, output wdata, output raddr, output erase, input rdata);
   modport mem  (input we, input waddr, input wdata, input raddr, input erase, output rdata);
endinterface // hcb_mem_if

/* hdl/hcb_cfg_mem.sv */
`timescale 1ns/1ps
`include "hcb_consts.svh"
module hcb_cfg_mem (
   input  wire logic clk_i,
   hcb_mem_if.mem    mem
);
   import hcb_pkg::*;
   // Models the nonvolatile array: contents are not cleared by reset, starting erased.
   // The declaration value gives the erased start without a second process driving the array.
   hcb_byte_t cell_r [128] = '{default: `HCB_ERASED_BYTE};
   hcb_byte_t rdata_r;
   always_ff @(posedge clk_i) begin
      if (mem.erase) begin
         for (int i = 0; i < 128; i++) begin
            cell_r[i] <= `HCB_ERASED_BYTE;
         end
      end else if (mem.we) begin
         cell_r[mem.waddr] <= mem.wdata;
      end
      rdata_r <= cell_r[mem.raddr];
   end
   assign mem.rdata = rdata_r;
endmodule // hcb_cfg_mem

/* hdl/hcb_config_bank.sv */
// Behaviour
// R1 - Reset-sector lock bit 5: 0 allows reset sector writes, 1 read-only.
// R2 - Boot ROM enable bit 4: 0 disables boot ROM, 1 enables it.
// R3 - Watchdog reset enable bit 3: 0 blocks watchdog resets, 1 permits.
// R4 - Data flash size code bits 2..0 decode to sizes; 111 none.
// R5 - Byte one written only in flash programming mode.
// R6 - Byte one readable at address 7Eh through the address/data pair.
// R7 - Digital brownout level bits 7..6: 4.5, 4.2, 2.7, 2.5 V.
// R8 - Analog brownout level bits 5..4 use the same encoding.
// R9 - Analog brownout disable bit 3 only acts with analog supply above 2.0V.
// R10 - Digital brownout disable bit 2: 0 enables reset, 1 disables.
// R11 - Bit 1 cleared gives port 0 and P3.6/P3.7 to external bus.
// R12 - Bit 0 cleared gives port 2 and P3.6/P3.7 to external bus.
// R13 - Configuration bits nonvolatile, changed only by programming interfaces.
// R14 - Byte zero at 7Fh, written in programming mode, read in user mode.
// R15 - Security bit blocks changes to bytes zero and one until mass erase.
// R16 - Program memory lock outranks reset-sector lock.
// R17 - Data register read returns selected byte without changing storage.
`timescale 1ns/1ps
`include "hcb_consts.svh"
module hcb_config_bank (
   input  wire logic                   clk_i,
   input  wire logic                   rstn_i,
   input  wire logic [7:0]             sfr_addr_i,
   input  wire logic [7:0]             sfr_wdata_i,
   input  wire logic                   sfr_wr_i,
   input  wire logic                   sfr_rd_i,
   output logic [7:0]                  sfr_rdata_o,
   output logic                        sfr_hit_o,
   input  wire logic                   prog_mode_i,
   input  wire logic                   mass_erase_i,
   input  wire logic                   avdd_above_2v0_i,
   output logic                        reset_sector_wr_en_o,
   output logic                        prog_mem_wr_en_o,
   output logic                        boot_rom_enable_o,
   output logic                        watchdog_reset_enable_o,
   output hcb_pkg::hcb_dflash_e        data_flash_size_code_o,
   output hcb_pkg::hcb_bo_level_e      digital_brownout_level_o,
   output hcb_pkg::hcb_bo_level_e      analog_brownout_level_o,
   output logic                        analog_brownout_rst_en_o,
   output logic                        digital_brownout_rst_en_o,
   output logic                        port0_ext_bus_o,
   output logic                        port2_ext_bus_o,
   output logic                        p3_strobes_ext_o,
   output logic                        programming_access_security_o
);
   import hcb_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   hcb_mem_if mif ();
   hcb_cfg_mem u_mem (
      .clk_i (clk_i),
      .mem   (mif)
   );

   hcb_byte_t config_address_select_r;
   hcb_byte_t config_address_select_nxt;
   hcb_byte_t hw_config_byte_zero_r;
   hcb_byte_t hw_config_byte_zero_nxt;
   hcb_byte_t hw_config_byte_one_r;
   hcb_byte_t hw_config_byte_one_nxt;
   logic      load_r;
   logic      load_nxt;
   logic [1:0] load_step_r;
   logic [1:0] load_step_nxt;

   function automatic logic is_sfr(input logic [7:0] a, input logic [7:0] target);
      is_sfr = (a == target);
   endfunction

   logic wr_sel;
   logic wr_data;
   logic locked;
   logic wr_ok;
   logic [6:0] tgt;
   assign wr_sel  = sfr_wr_i && is_sfr(sfr_addr_i, `HCB_SFR_ADDR_SEL);
   assign wr_data = sfr_wr_i && is_sfr(sfr_addr_i, `HCB_SFR_DATA_PORT);
   assign tgt     = config_address_select_r[6:0];
   // R15 security lock
   assign locked  = !hw_config_byte_zero_r[`HCB_B0_SECURITY] &&
                    (tgt == `HCB_CFG_BYTE_ZERO || tgt == `HCB_CFG_BYTE_ONE);
   // R5 R13 R14 programming mode only
   assign wr_ok   = wr_data && prog_mode_i && !locked && !load_r;

   ////////////////////////////////////////////////////////////////////////////
   // The two system bytes are shadowed after reset so outputs never wait on the array.
   always_comb begin
      config_address_select_nxt = config_address_select_r;
      hw_config_byte_zero_nxt   = hw_config_byte_zero_r;
      hw_config_byte_one_nxt    = hw_config_byte_one_r;
      load_nxt                  = load_r;
      load_step_nxt             = load_step_r;
      if (wr_sel) begin
         config_address_select_nxt = sfr_wdata_i;
      end
      if (load_r) begin
         load_step_nxt = load_step_r + 2'd1;
         if (load_step_r == 2'd1) begin
            hw_config_byte_zero_nxt = mif.rdata;
         end
         if (load_step_r == 2'd2) begin
            hw_config_byte_one_nxt = mif.rdata;
            load_nxt = 1'b0;
         end
      end else if (mass_erase_i) begin
         hw_config_byte_zero_nxt = `HCB_ERASED_BYTE;
         hw_config_byte_one_nxt  = `HCB_ERASED_BYTE;
      end else if (wr_ok && tgt == `HCB_CFG_BYTE_ZERO) begin
         hw_config_byte_zero_nxt = sfr_wdata_i;
      end else if (wr_ok && tgt == `HCB_CFG_BYTE_ONE) begin
         hw_config_byte_one_nxt = sfr_wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         config_address_select_r <= `HCB_ADDR_RESET;
         hw_config_byte_zero_r   <= `HCB_ERASED_BYTE;
         hw_config_byte_one_r    <= `HCB_ERASED_BYTE;
         load_r                  <= 1'b1;
         load_step_r             <= 2'd0;
      end else begin
         config_address_select_r <= config_address_select_nxt;
         hw_config_byte_zero_r   <= hw_config_byte_zero_nxt;
         hw_config_byte_one_r    <= hw_config_byte_one_nxt;
         load_r                  <= load_nxt;
         load_step_r             <= load_step_nxt;
      end
   end

   always_comb begin
      mif.erase = mass_erase_i && !load_r;
      mif.we    = wr_ok && !mass_erase_i;
      mif.waddr = tgt;
      mif.wdata = sfr_wdata_i;
      if (load_r) begin
         mif.raddr = (load_step_r == 2'd0) ? `HCB_CFG_BYTE_ZERO : `HCB_CFG_BYTE_ONE;
      end else begin
         mif.raddr = tgt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reads are combinational; the data port gives the shadow byte for 7Eh/7Fh, else the array word one cycle after addressing.
   // R6 R14 R17 readback
   always_comb begin
      sfr_hit_o   = is_sfr(sfr_addr_i, `HCB_SFR_ADDR_SEL) || is_sfr(sfr_addr_i, `HCB_SFR_DATA_PORT);
      sfr_rdata_o = 8'h00;
      if (sfr_rd_i && is_sfr(sfr_addr_i, `HCB_SFR_ADDR_SEL)) begin
         sfr_rdata_o = config_address_select_r;
      end else if (sfr_rd_i && is_sfr(sfr_addr_i, `HCB_SFR_DATA_PORT)) begin
         if (tgt == `HCB_CFG_BYTE_ZERO) begin
            sfr_rdata_o = hw_config_byte_zero_r;
         end else if (tgt == `HCB_CFG_BYTE_ONE) begin
            sfr_rdata_o = hw_config_byte_one_r;
         end else begin
            sfr_rdata_o = mif.rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign programming_access_security_o = hw_config_byte_zero_r[`HCB_B0_SECURITY];
   // R16 R1 lock priority
   assign prog_mem_wr_en_o     = !hw_config_byte_zero_r[`HCB_B0_PROG_LOCK];
   assign reset_sector_wr_en_o = !hw_config_byte_zero_r[`HCB_B0_PROG_LOCK] &&
                                 !hw_config_byte_zero_r[`HCB_B0_RESET_LOCK];
   // R2 boot ROM
   assign boot_rom_enable_o       = hw_config_byte_zero_r[`HCB_B0_BOOT_ROM];
   // R3 watchdog reset
   assign watchdog_reset_enable_o = hw_config_byte_zero_r[`HCB_B0_WDOG_RESET];
   // R4 data flash size
   assign data_flash_size_code_o  = hcb_dflash_e'(hw_config_byte_zero_r[`HCB_B0_DFLASH_HI:`HCB_B0_DFLASH_LO]);
   // R7 R8 brownout levels
   assign digital_brownout_level_o = hcb_bo_level_e'(hw_config_byte_one_r[`HCB_B1_DBO_HI:`HCB_B1_DBO_LO]);
   assign analog_brownout_level_o  = hcb_bo_level_e'(hw_config_byte_one_r[`HCB_B1_ABO_HI:`HCB_B1_ABO_LO]);
   // R9 analog disable gated by supply
   assign analog_brownout_rst_en_o  = !(hw_config_byte_one_r[`HCB_B1_ABO_DIS] && avdd_above_2v0_i);
   // R10 digital disable
   assign digital_brownout_rst_en_o = !hw_config_byte_one_r[`HCB_B1_DBO_DIS];
   // R11 R12 port functions
   assign port0_ext_bus_o  = !hw_config_byte_one_r[`HCB_B1_P0_GPIO];
   assign port2_ext_bus_o  = !hw_config_byte_one_r[`HCB_B1_P23_GPIO];
   assign p3_strobes_ext_o = port0_ext_bus_o || port2_ext_bus_o;
endmodule // hcb_config_bank

/* testbench/hcb_config_bank_sva.sv */
`timescale 1ns/1ps
module hcb_config_bank_sva
   import hcb_pkg::*;
(
   input wire logic          clk_i,
   input wire logic          rstn_i,
   input wire logic [7:0]    sfr_addr_i,
   input wire logic [7:0]    sfr_wdata_i,
   input wire logic          sfr_wr_i,
   input wire logic          sfr_rd_i,
   input wire logic [7:0]    sfr_rdata_o,
   input wire logic          sfr_hit_o,
   input wire logic          prog_mode_i,
   input wire logic          mass_erase_i,
   input wire logic          avdd_above_2v0_i,
   input wire logic          reset_sector_wr_en_o,
   input wire logic          prog_mem_wr_en_o,
   input wire logic          boot_rom_enable_o,
   input wire hcb_bo_level_e digital_brownout_level_o,
   input wire logic          analog_brownout_rst_en_o,
   input wire logic          port0_ext_bus_o,
   input wire logic          port2_ext_bus_o,
   input wire logic          p3_strobes_ext_o,
   input wire logic          programming_access_security_o
);
   logic [2:0] cnt_r;
   logic [2:0] cnt_nxt;
   // The shadow load runs for three edges after reset, so the user-mode and byte-one checks wait for it.
   always_comb begin
      cnt_nxt = (cnt_r == 3'h4) ? cnt_r : cnt_r + 3'h1;
   end
   always_ff @(posedge clk_i) begin
      cnt_r <= rstn_i ? cnt_nxt : 3'h0;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   ////////////////////////////////////////////////////////////////////////////
   a_hit_decode: assert property (sfr_hit_o == (sfr_addr_i == 8'h93 || sfr_addr_i == 8'h94))
      else $error("hit flag does not match the address");
   a_unmapped_zero: assert property (sfr_rd_i && !sfr_hit_o |-> sfr_rdata_o == 8'h00)
      else $error("unmapped read returned nonzero data");
   a_strobe_either: assert property (p3_strobes_ext_o == (port0_ext_bus_o | port2_ext_bus_o))
      else $error("strobe select is not the union of the port selects");
   a_lock_priority: assert property (reset_sector_wr_en_o |-> prog_mem_wr_en_o)
      else $error("reset sector writable while program memory locked");
   a_abo_low_supply: assert property (!avdd_above_2v0_i |-> analog_brownout_rst_en_o)
      else $error("analog brownout reset off with low analog supply");
   a_user_no_change: assert property (cnt_r == 3'h4 && $past(cnt_r) == 3'h4 && !$past(prog_mode_i)
      && !$past(mass_erase_i) |-> $stable({boot_rom_enable_o, prog_mem_wr_en_o, digital_brownout_level_o,
      port0_ext_bus_o, programming_access_security_o}))
      else $error("configuration changed outside programming mode");
   a_erase_default: assert property (mass_erase_i |=> boot_rom_enable_o && programming_access_security_o
      && !prog_mem_wr_en_o && digital_brownout_level_o == HCB_BO_2V5)
      else $error("mass erase did not restore defaults");
   a_addr_readback: assert property (sfr_wr_i && sfr_addr_i == 8'h93 ##2 sfr_rd_i && !sfr_wr_i
      && sfr_addr_i == 8'h93 |-> sfr_rdata_o[6:0] == $past(sfr_wdata_i[6:0], 2))
      else $error("address select did not read back");
   a_byte_one_write: assert property (sfr_wr_i && sfr_addr_i == 8'h93 && sfr_wdata_i[6:0] == 7'h7e ##2
      sfr_wr_i && sfr_addr_i == 8'h94 && prog_mode_i && programming_access_security_o && !mass_erase_i
      && cnt_r == 3'h4 |=> digital_brownout_level_o == $past(sfr_wdata_i[7:6])
      && port2_ext_bus_o == !$past(sfr_wdata_i[0]))
      else $error("byte one write did not reach the outputs");
   c_erase: cover property (mass_erase_i);
   c_prog_write: cover property (sfr_wr_i && sfr_addr_i == 8'h94 && prog_mode_i);
   c_data_read: cover property (sfr_rd_i && sfr_addr_i == 8'h94);
endmodule // hcb_config_bank_sva
bind hcb_config_bank hcb_config_bank_sva hcb_config_bank_sva_i (.*);

/* testbench/hcb_config_bank_tb.sv */
`timescale 1ns/1ps
module hcb_config_bank_tb;
   import hcb_pkg::*;
   logic          clk_i, rstn_i, sfr_wr_i, sfr_rd_i, sfr_hit_o, prog_mode_i, mass_erase_i, avdd_above_2v0_i;
   logic [7:0]    sfr_addr_i, sfr_wdata_i, sfr_rdata_o, v0, v1;
   logic          reset_sector_wr_en_o, prog_mem_wr_en_o, boot_rom_enable_o, watchdog_reset_enable_o;
   logic          analog_brownout_rst_en_o, digital_brownout_rst_en_o, port0_ext_bus_o, port2_ext_bus_o;
   logic          p3_strobes_ext_o, programming_access_security_o;
   hcb_dflash_e   data_flash_size_code_o;
   hcb_bo_level_e digital_brownout_level_o, analog_brownout_level_o;
   int            err_total, num_checks;
   wire [7:0] o0 = {programming_access_security_o, prog_mem_wr_en_o, reset_sector_wr_en_o, boot_rom_enable_o,
                    watchdog_reset_enable_o, data_flash_size_code_o};
   wire [8:0] o1 = {digital_brownout_level_o, analog_brownout_level_o, analog_brownout_rst_en_o,
                    digital_brownout_rst_en_o, port0_ext_bus_o, port2_ext_bus_o, p3_strobes_ext_o};
   hcb_config_bank hcb_config_bank_i (.*);
   ////////////////////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr_addr_i  <= a;
      sfr_wdata_i <= d;
      sfr_wr_i    <= 1'b1;
      @(posedge clk_i);
      sfr_wr_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic rs(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_i);
      sfr_addr_i <= a;
      sfr_rd_i   <= 1'b1;
      @(negedge clk_i);
      chk("read data", {1'b0, exp}, {1'b0, sfr_rdata_o});
      @(posedge clk_i);
      sfr_rd_i <= 1'b0;
      @(negedge clk_i);
   endtask
   // Expected outputs follow directly from the stored bytes and the supply level.
   task automatic bank(input logic [7:0] e0, input logic [7:0] e1);
      wr(8'h93, 8'h7f);
      rs(8'h94, e0);
      wr(8'h93, 8'h7e);
      rs(8'h94, e1);
      chk("byte zero outputs", {1'b0, e0[7], ~e0[6], ~e0[6] & ~e0[5], e0[4:0]}, {1'b0, o0});
      chk("byte one outputs", {e1[7:4], ~(e1[3] & avdd_above_2v0_i), ~e1[2:0], ~(e1[1] & e1[0])}, o1);
   endtask
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      report_and_stop();
   end
   initial begin
      {rstn_i, sfr_wr_i, sfr_rd_i, prog_mode_i, mass_erase_i} = 5'h00;
      {sfr_addr_i, sfr_wdata_i} = 16'h0000;
      avdd_above_2v0_i = 1'b1;
      err_total = 0;
      num_checks = 0;
      repeat (10) @(posedge clk_i);
      rstn_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      bank(8'hff, 8'hff);
      rs(8'h95, 8'h00);
      wr(8'h93, 8'h7e);
      wr(8'h94, 8'h00);
      bank(8'hff, 8'hff);
      wr(8'h93, 8'h25);
      rs(8'h93, 8'h25);
      @(posedge clk_i);
      prog_mode_i <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         v1 = {i[1:0], i[1:0], i[0], ~i[0], i[1], i[0]};
         wr(8'h93, 8'h7e);
         wr(8'h94, v1);
         bank(8'hff, v1);
      end
      wr(8'h93, 8'h10);
      wr(8'h94, 8'ha5);
      rs(8'h94, 8'ha5);
      @(posedge clk_i);
      avdd_above_2v0_i <= 1'b0;
      bank(8'hff, v1);
      for (int i = 0; i < 8; i++) begin
         v0 = {1'b1, i[0], i[1], i[2], ~i[0], i[2:0]};
         wr(8'h93, 8'h7f);
         wr(8'h94, v0);
         bank(v0, v1);
      end
      // Clearing the security bit must freeze both bytes until an erase.
      wr(8'h93, 8'h7f);
      wr(8'h94, 8'h7f);
      wr(8'h94, 8'hff);
      wr(8'h93, 8'h7e);
      wr(8'h94, 8'h00);
      bank(8'h7f, v1);
      @(posedge clk_i);
      mass_erase_i <= 1'b1;
      @(posedge clk_i);
      mass_erase_i <= 1'b0;
      bank(8'hff, 8'hff);
      report_and_stop();
   end
endmodule // hcb_config_bank_tb
